// File: rtl/lcss_line.sv
// Purpose: one input line: inversion and change detection
// Assumes: level already synchronised to i_mclk
// Notes: change is flagged in the same cycle as the synchronised edge
`timescale 1ns/100ps
module lcss_line (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_level,
  input wire logic i_invert,
  output logic o_active,
  output logic o_change
);

  lcss_pkg::lcss_line_t r;
  lcss_pkg::lcss_line_t next_r;

  // remember the last level to spot a transition
  always_comb begin
    next_r = r;
    next_r.prev = i_level;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // high means active unless the line is inverted
  assign o_active = i_level ^ i_invert;
  assign o_change = i_level ^ r.prev;

endmodule

// File: rtl/lcss_sync.sv
// Purpose: two flip-flop synchronisers for the trigger and both lines
// Assumes: one clock, clock enable freezes both stages
// Notes: the first stage is read only by the second
`timescale 1ns/100ps
module lcss_sync (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [2:0] i_raw,
  output logic [2:0] o_sync
);

  lcss_pkg::lcss_sync_t r;
  lcss_pkg::lcss_sync_t next_r;
  logic [2:0] d1;
  logic [2:0] d2;

  // ==========================================================
  // per-bit two stage chain, one driver per bit
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bit
      assign d1[g] = i_raw[g];
      assign d2[g] = r.s1[g];
    end
  endgenerate

  // single process fills the whole record to keep one driver
  always_comb begin
    next_r = r;
    next_r.s1 = d1;
    next_r.s2 = d2;
  end

  // state register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_sync = r.s2;

endmodule

// File: rtl/lcss_top.sv
// Purpose: picks the active sequence set on each frame start trigger
// Assumes: APB slave, 100 MHz clock, acquisition end from the sensor
// Notes: parameter contents live elsewhere; this block gives the index
// Summary of operation
// R1: enabling starts cycle by loading set 0
// R2: restart source is the non-advance line
// R3: each accepted trigger samples both lines
// R4: restart active selects set 0, ignores advance
// R5: restart inactive leaves choice to advance
// R6: advance active loads next higher set
// R7: advance inactive keeps current set
// R8: set count bounds indices 0..count-1
// R9: trigger edge selectable, rising by default
// R10: each line has selectable inversion
// R11: after restart advance continues from 0
// R12: line change leaves waiting status briefly
// R13: triggers outside waiting status are dropped
// R14: far side triggers only while waiting
// R15: advance after highest set wraps to 0
// R16: disable after acquisition restores base set
// R17: lines and trigger synchronised before use
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "lcss_cfg.svh"
module lcss_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_line1,
  input wire logic i_line2,
  input wire logic i_trig,
  input wire logic i_acq_done,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic [3:0] o_set_index,
  output logic o_seq_on,
  output logic o_load,
  output logic o_acq_start,
  output logic o_wait_trig,
  output logic o_trig_drop
);

  // ==========================================================
  // state record
  typedef struct packed {
    lcss_pkg::lcss_state_t st;
    logic seq_on;
    logic [`LCSS_SET_W-1:0] set;
    logic [`LCSS_SET_W-1:0] count;
    logic [`LCSS_CTRL_W-1:0] ctrl;
    logic [`LCSS_SETTLE_W-1:0] settle;
    logic [`LCSS_DROP_W-1:0] drops;
    logic trig_prev;
    logic wait_trig;
    logic load;
    logic acq_start;
    logic drop;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lcss_regs_t;

  localparam logic [`LCSS_SETTLE_W-1:0] SETTLE_CYC =
    `LCSS_SETTLE_W'(`LCSS_SETTLE_CYC);

  lcss_regs_t r;
  lcss_regs_t next_r;

  // ==========================================================
  // input conditioning
  logic [2:0] sync;
  logic [1:0] line_act;
  logic [1:0] line_chg;
  logic [1:0] line_inv;

  lcss_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_raw({i_trig, i_line2, i_line1}),
    .o_sync(sync)
  ); // R17

  assign line_inv = {r.ctrl[`LCSS_CTRL_INV2], r.ctrl[`LCSS_CTRL_INV1]};

  // one conditioner per input line
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      lcss_line u_line (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_level(sync[g]),
        .i_invert(line_inv[g]), // R10
        .o_active(line_act[g]),
        .o_change(line_chg[g])
      );
    end
  endgenerate

  // ==========================================================
  // decision terms
  logic adv_act;
  logic rst_act;
  logic rst_hit;
  logic trig_edge;
  logic waiting;
  logic accept;
  logic any_chg;
  logic last_set;
  logic [`LCSS_SET_W-1:0] set_inc;
  logic apb_go;
  logic apb_wr;

  always_comb begin
    // advance line chosen by software, restart on the other one
    adv_act = r.ctrl[`LCSS_CTRL_ADV_SEL] ? line_act[1] : line_act[0];
    rst_act = r.ctrl[`LCSS_CTRL_ADV_SEL] ? line_act[0] : line_act[1]; // R2
    rst_hit = r.ctrl[`LCSS_CTRL_RST_EN] & rst_act;
    // falling edge only if software asks; rising otherwise
    trig_edge = r.ctrl[`LCSS_CTRL_FALL] ? (r.trig_prev & ~sync[2])
                                        : (~r.trig_prev & sync[2]); // R9
    any_chg = |line_chg;
    waiting = (r.st == lcss_pkg::ST_WAIT) & ~any_chg;
    accept = trig_edge & waiting;
    set_inc = `LCSS_SET_W'(r.set + `LCSS_SET_W'(1));
    // a count of zero behaves like one: index stays at 0
    last_set = ({1'b0, r.set} + 5'h01) >= {1'b0, r.count}; // R8
    apb_go = i_psel & i_penable & r.pready;
    apb_wr = apb_go & i_pwrite;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.load = 1'b0;
    next_r.acq_start = 1'b0;
    next_r.drop = 1'b0;
    next_r.trig_prev = sync[2];

    // sequencing state machine
    case (r.st)
      lcss_pkg::ST_WAIT: begin
        if (any_chg) begin
          next_r.st = lcss_pkg::ST_HOLD; // R12
          next_r.settle = SETTLE_CYC;
        end
        if (accept) begin
          next_r.st = lcss_pkg::ST_ACQ;
          next_r.acq_start = 1'b1;
          if (r.seq_on) begin
            // both lines sampled at the same accepted edge
            if (rst_hit) begin // R3
              next_r.set = '0; // R4 R11
              next_r.load = 1'b1;
            end else if (adv_act) begin // R5
              next_r.set = last_set ? '0 : set_inc; // R6 R15
              next_r.load = 1'b1;
            end else begin
              next_r.set = r.set; // R7
            end
          end
        end else if (trig_edge) begin
          next_r.drop = 1'b1; // R13
        end
      end
      lcss_pkg::ST_HOLD: begin
        // out of waiting status until the lines have stood still
        if (trig_edge) begin
          next_r.drop = 1'b1; // R13
        end
        if (any_chg) begin
          next_r.settle = SETTLE_CYC;
        end else if (r.settle <= `LCSS_SETTLE_W'(1)) begin
          next_r.settle = '0;
          next_r.st = lcss_pkg::ST_WAIT;
        end else begin
          next_r.settle = r.settle - `LCSS_SETTLE_W'(1);
        end
      end
      lcss_pkg::ST_ACQ: begin
        // triggers during exposure and readout are not taken
        if (trig_edge) begin
          next_r.drop = 1'b1;
        end
        if (any_chg) begin
          next_r.settle = SETTLE_CYC;
        end else if (r.settle != '0) begin
          next_r.settle = r.settle - `LCSS_SETTLE_W'(1);
        end
        if (i_acq_done) begin
          next_r.st = (any_chg || r.settle > `LCSS_SETTLE_W'(1))
                      ? lcss_pkg::ST_HOLD : lcss_pkg::ST_WAIT;
        end
      end
      default: begin
        next_r.st = lcss_pkg::ST_WAIT;
      end
    endcase

    // enable and disable act only between acquisitions
    if (r.st != lcss_pkg::ST_ACQ && next_r.st != lcss_pkg::ST_ACQ) begin
      if (r.ctrl[`LCSS_CTRL_EN] && !r.seq_on) begin
        next_r.seq_on = 1'b1;
        next_r.set = '0; // R1
        next_r.load = 1'b1;
      end else if (!r.ctrl[`LCSS_CTRL_EN] && r.seq_on) begin
        next_r.seq_on = 1'b0; // R16
        next_r.set = '0;
      end
    end

    // waiting flag as an output register
    next_r.wait_trig = (next_r.st == lcss_pkg::ST_WAIT);

    // dropped trigger counter; a drop beats a clearing write
    if (apb_wr && i_paddr == `LCSS_OFF_DROPS) begin
      next_r.drops = '0;
    end
    if (next_r.drop && next_r.drops != '1) begin
      next_r.drops = next_r.drops + `LCSS_DROP_W'(1);
    end

    // APB slave: one wait state, answer registered
    next_r.pready = i_psel & i_penable & ~r.pready;
    next_r.pslverr = 1'b0;
    next_r.prdata = '0;
    if (i_psel && i_penable && !r.pready) begin
      case (i_paddr)
        `LCSS_OFF_CTRL: begin
          next_r.prdata = {26'h0, r.ctrl};
        end
        `LCSS_OFF_COUNT: begin
          next_r.prdata = {28'h0, r.count};
        end
        `LCSS_OFF_STATUS: begin
          next_r.prdata = {25'h0, r.st == lcss_pkg::ST_ACQ, r.wait_trig,
                           r.seq_on, r.set};
        end
        `LCSS_OFF_DROPS: begin
          next_r.prdata = {24'h0, r.drops};
        end
        default: begin
          next_r.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr && i_paddr == `LCSS_OFF_CTRL) begin
      next_r.ctrl = i_pwdata[`LCSS_CTRL_W-1:0];
    end
    if (apb_wr && i_paddr == `LCSS_OFF_COUNT) begin
      next_r.count = i_pwdata[`LCSS_SET_W-1:0];
    end
  end

  // ==========================================================
  // state register, frozen while the clock enable is low
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{st: lcss_pkg::ST_WAIT, seq_on: 1'b0, set: '0,
             count: `LCSS_COUNT_RESET, ctrl: `LCSS_CTRL_RESET,
             settle: '0, drops: '0, trig_prev: 1'b0, wait_trig: 1'b1,
             load: 1'b0, acq_start: 1'b0, drop: 1'b0, pready: 1'b0,
             pslverr: 1'b0, prdata: '0};
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign o_pready = r.pready;
  assign o_prdata = r.prdata;
  assign o_pslverr = r.pslverr;
  assign o_set_index = r.set;
  assign o_seq_on = r.seq_on;
  assign o_load = r.load;
  assign o_acq_start = r.acq_start;
  assign o_wait_trig = r.wait_trig;
  assign o_trig_drop = r.drop;

  // ==========================================================
  // checks
  a_enable_set_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(r.seq_on) |-> r.set == '0 && r.load) // R1
    else $error("enable did not load set 0");

  a_restart_first: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && accept && r.seq_on && rst_hit |=> r.set == '0 && r.load)
    // R4
    else $error("restart did not select set 0");

  a_advance_next: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && accept && r.seq_on && !rst_hit && adv_act && !last_set
    |=> r.set == $past(set_inc)) // R6
    else $error("advance did not step to next set");

  a_wrap_to_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && accept && r.seq_on && !rst_hit && adv_act && last_set
    |=> r.set == '0) // R15
    else $error("advance past last set did not wrap");

  a_hold_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && accept && r.seq_on && !rst_hit && !adv_act
    |=> $stable(r.set) && !r.load) // R7
    else $error("set changed without advance");

  a_drop_busy: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && trig_edge && !waiting |=> r.drop && !r.acq_start) // R13
    else $error("trigger outside waiting not dropped");

  a_change_leave: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && any_chg |=> !r.wait_trig [*8]) // R12
    else $error("waiting status kept after line change");

  a_edge_start: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_ce && trig_edge && waiting
    |=> r.acq_start ##1 (!r.acq_start || !$past(i_ce))) // R9
    else $error("accepted trigger gave no single start pulse");

  a_disable_base: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(r.seq_on) |-> $past(r.st) != lcss_pkg::ST_ACQ
                        && !r.ctrl[`LCSS_CTRL_EN]) // R16
    else $error("sequencer left during an acquisition");

endmodule

// File: shared/lcss_cfg.svh
// Purpose: constants of the line controlled sequence set selector
// Assumes: 100 MHz clock, APB register access with 32-bit data
// Notes: definitions only
`ifndef LCSS_CFG_SVH
`define LCSS_CFG_SVH

// ==========================================================
// register offsets (byte addresses)
`define LCSS_OFF_CTRL 8'h00
`define LCSS_OFF_COUNT 8'h04
`define LCSS_OFF_STATUS 8'h08
`define LCSS_OFF_DROPS 8'h0c

// ==========================================================
// control register fields
`define LCSS_CTRL_EN 0
`define LCSS_CTRL_ADV_SEL 1
`define LCSS_CTRL_RST_EN 2
`define LCSS_CTRL_INV1 3
`define LCSS_CTRL_INV2 4
`define LCSS_CTRL_FALL 5
`define LCSS_CTRL_W 6
`define LCSS_CTRL_RESET 6'h00

// ==========================================================
// set count, index and status fields
`define LCSS_SET_W 4
`define LCSS_COUNT_RESET 4'h6
`define LCSS_ST_SEQ_ON 4
`define LCSS_ST_WAIT 5
`define LCSS_ST_BUSY 6
`define LCSS_DROP_W 8

// ==========================================================
// line settle window after a line change
`define LCSS_CLK_NS 10
`define LCSS_SETTLE_NS 1000
`define LCSS_SETTLE_CYC \
  ((`LCSS_SETTLE_NS + `LCSS_CLK_NS - 1) / `LCSS_CLK_NS)
`define LCSS_SETTLE_W 7

`endif

// File: shared/lcss_pkg.sv
// Purpose: types of the line controlled sequence set selector
// Assumes: constants come from lcss_cfg.svh
// Notes: holds the state enum and the state records of lcss_sync and lcss_line
package lcss_pkg;

  // ==========================================================
  // sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_HOLD = 3'b010,
    ST_ACQ = 3'b100
  } lcss_state_t;

  // ==========================================================
  // state records
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } lcss_sync_t;

  typedef struct packed {
    logic prev;
  } lcss_line_t;

endpackage

// File: testbench/lcss_far_model.sv
// Purpose: far side model: trigger source and sensor acquisition end
// Assumes: bench sets the line levels itself and asks for triggers
// Notes: rude request skips the wait for the waiting status
`timescale 1ns/100ps
module lcss_far_model (
  input wire logic i_mclk,
  input wire logic i_wait_trig,
  input wire logic i_acq_start,
  input wire logic i_go,
  input wire logic i_rude,
  output logic o_trig,
  output logic o_acq_done
);
  logic [3:0] done_sr;

  // ==========================================================
  // trigger: lines settle first, then a rising edge held 3 cycles
  initial begin
    o_trig = 1'b0;
    forever begin
      @(posedge i_mclk);
      if (i_go) begin
        repeat (4) @(posedge i_mclk);
        // polite source fires only while the device waits
        while (!i_rude && i_wait_trig !== 1'b1) @(posedge i_mclk);
        o_trig <= 1'b1;
        repeat (3) @(posedge i_mclk);
        o_trig <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sensor: exposure ends a few cycles after the start pulse
  initial done_sr = 4'h0;
  initial o_acq_done = 1'b0;
  always @(posedge i_mclk) begin
    done_sr <= {done_sr[2:0], i_acq_start};
    o_acq_done <= done_sr[3];
  end
endmodule

// File: testbench/tb_line_controlled_sequence_set_selector.sv
// Purpose: self-checking bench of the sequence set selector
// Assumes: APB answers with one wait state, settle of 100 cycles
// Notes: random line levels from an xorshift seeded with 1
`timescale 1ns/100ps
module tb_line_controlled_sequence_set_selector;
  logic i_mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, q;
  logic line1 = 1'b0, line2 = 1'b0, go = 1'b0, rude = 1'b0, e;
  logic trig, acq_done, o_pready, o_pslverr, o_seq_on, o_load;
  logic o_acq_start, o_wait_trig, o_trig_drop;
  logic [31:0] o_prdata;
  logic [3:0] o_set_index, cur, cnt;
  logic sel, inv, ce = 1'b1;
  int err_count = 0, checks = 0, cyc = 0;
  logic [31:0] seed = 32'h1;

  always #5 i_mclk = ~i_mclk;

  lcss_top dut (.i_mclk(i_mclk), .i_rst(rst), .i_ce(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_line1(line1),
    .i_line2(line2), .i_trig(trig), .i_acq_done(acq_done),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_set_index(o_set_index), .o_seq_on(o_seq_on), .o_load(o_load),
    .o_acq_start(o_acq_start), .o_wait_trig(o_wait_trig),
    .o_trig_drop(o_trig_drop));

  lcss_far_model far (.i_mclk(i_mclk), .i_wait_trig(o_wait_trig),
    .i_acq_start(o_acq_start), .i_go(go), .i_rude(rude),
    .o_trig(trig), .o_acq_done(acq_done));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected index: restart beats advance, advance wraps at count
  function automatic logic [3:0] nxt(input logic r, input logic a);
    if (r) return 4'h0;
    if (!a) return cur;
    return (cur + 4'h1 >= cnt) ? 4'h0 : cur + 4'h1;
  endfunction

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    q = o_prdata;
    e = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return o_acq_start;
      1: return o_wait_trig;
      default: return o_trig_drop;
    endcase
  endfunction

  // bounded wait on a design flag, judged at the falling edge
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    while (sig(k) !== 1'b1 && n < 2000) begin
      @(negedge i_mclk);
      n++;
    end
    chk("flag", {31'h0, sig(k)}, 32'h1);
  endtask

  // set the lines (active levels), ask for a trigger, check the set
  task automatic step(input logic r, input logic a);
    @(posedge i_mclk);
    line1 <= (sel ? r : a) ^ inv;
    line2 <= (sel ? a : r) ^ inv;
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    wait_hi(0);
    chk("set_index", o_set_index, nxt(r, a));
    chk("load", {31'h0, o_load}, {31'h0, r | a});
    cur = nxt(r, a);
    wait_hi(1);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge i_mclk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", q, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("count", q, 32'h6);
    apb(1'b0, 8'h08, 32'h0);
    chk("status", q, 32'h20);
    apb(1'b1, 8'h10, 32'h1);
    chk("unmapped", {31'h0, e}, 32'h1);
    for (int c = 0; c < 2; c++) begin
      sel = c[0];
      inv = c[0];
      cnt = c ? 4'h3 : 4'h6;
      cur = 4'h0;
      apb(1'b1, 8'h04, {28'h0, cnt});
      // enable with restart on the other line
      // second pass also moves the trigger to its falling edge
      apb(1'b1, 8'h00, {26'h0, c[0], inv, inv, 3'b101} | {30'h0, sel, 1'b0});
      wait_hi(1);
      apb(1'b0, 8'h08, 32'h0);
      chk("enable", q & 32'h1f, 32'h10);
      // clock enable low must freeze the synchronisers as well
      @(posedge i_mclk);
      ce <= 1'b0;
      line2 <= ~line2;
      repeat (6) @(negedge i_mclk);
      chk("frozen", {31'h0, o_wait_trig}, 32'h1);
      @(posedge i_mclk);
      ce <= 1'b1;
      repeat (5) @(negedge i_mclk);
      chk("ce_chg", {31'h0, o_wait_trig}, 32'h0);
      wait_hi(1);
      for (int i = 0; i < 25; i++)
        step(rnd() % 5 == 0, rnd() % 3 != 0);
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
      // trigger sent during a line change is thrown away
      @(posedge i_mclk);
      line1 <= ~line1;
      rude <= 1'b1;
      go <= 1'b1;
      @(posedge i_mclk);
      go <= 1'b0;
      repeat (4) @(negedge i_mclk);
      chk("wait_trig", {31'h0, o_wait_trig}, 32'h0);
      wait_hi(2);
      rude <= 1'b0;
      wait_hi(1);
      apb(1'b0, 8'h0c, 32'h0);
      chk("drops", q, 32'h1);
      apb(1'b1, 8'h0c, 32'h0);
      // disable brings back base parameters
      apb(1'b1, 8'h00, 32'h0);
      repeat (3) @(negedge i_mclk);
      chk("seq_on", {27'h0, o_seq_on, o_set_index}, 32'h0);
    end
    summarize();
  end
endmodule
